// file: sec_pkg.sv
/*
  Constants for the status and exception control block: status word layout,
  mode codes, exception vectors, register file layout and register offsets.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package sec_pkg;
  // Mode field codes
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1B;
  localparam logic [4:0] MODE_SYS = 5'h1F;
  // Status word bit positions
  localparam int BIT_N = 31;
  localparam int BIT_Z = 30;
  localparam int BIT_C = 29;
  localparam int BIT_V = 28;
  localparam int BIT_I = 7;
  localparam int BIT_F = 6;
  localparam int BIT_T = 5;
  localparam logic [31:0] STATUS_RST = 32'h000000D3;
  // Exception slots, lowest number wins
  localparam logic [2:0] EXC_ABT = 3'h0;
  localparam logic [2:0] EXC_FIQ = 3'h1;
  localparam logic [2:0] EXC_IRQ = 3'h2;
  localparam logic [2:0] EXC_UND = 3'h3;
  localparam logic [2:0] EXC_SWI = 3'h4;
  localparam logic [2:0] EXC_NONE = 3'h7;
  localparam logic [31:0] VEC_UND = 32'h00000004;
  localparam logic [31:0] VEC_SWI = 32'h00000008;
  localparam logic [31:0] VEC_ABT = 32'h00000010;
  localparam logic [31:0] VEC_IRQ = 32'h00000018;
  localparam logic [31:0] VEC_FIQ = 32'h0000001C;
  // Physical register file layout
  localparam logic [4:0] RF_FIQ_LO = 5'h0F;
  localparam logic [4:0] RF_BANK_USR = 5'h0D;
  localparam logic [4:0] RF_BANK_FIQ = 5'h14;
  localparam logic [4:0] RF_BANK_IRQ = 5'h16;
  localparam logic [4:0] RF_BANK_SVC = 5'h18;
  localparam logic [4:0] RF_BANK_ABT = 5'h1A;
  localparam logic [4:0] RF_BANK_UND = 5'h1C;
  localparam int RF_WORDS = 30;
  // Register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_SAVED = 8'h04;
  localparam logic [7:0] OFF_PEND = 8'h08;
  localparam logic [7:0] OFF_LINK = 8'h0C;
endpackage
`default_nettype wire

// file: status_and_exception_control.sv
/*
  Status word, saved status words, banked registers and exception entry and
  return for a 32-bit core, with an AHB-Lite register slave.
  Assumes fast and normal interrupt pins are asynchronous levels; abort,
  undefined and trap requests are one-cycle pulses from the pipeline clock.
// Function
// - Keep four condition flags N Z C V in the status word.
// - Keep two interrupt-disable bits, one fast and one normal.
// - Keep one bit selecting wide or compact instruction state.
// - Keep a five-bit mode field in the status word.
// - Each exception mode owns a saved word holding the prior status.
// - Recognise five exception types, each with its own mode.
// - Requests arriving together are all kept, none lost.
// - Entry saves return address in target link and status in saved word.
// - Return copies saved word to status and link to program counter.
// - Data-processing with status update and PC destination returns.
// - Load-multiple restoring status while loading PC also returns.
// - Wide instructions run only when their top four-bit condition holds.
// - Compact state low registers 0-7 share the wide state registers.
// - Instructions are 32-bit words in wide and halfwords in compact.
// - Each exception mode has its own banked stack pointer.
// - Fast interrupt mode also banks registers 8 to 12.
*/
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
module status_and_exception_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic fast_interrupt_pin,
  input wire logic irq_pin,
  input wire logic abort_req,
  input wire logic undef_req,
  input wire logic software_trap_req,
  input wire logic take_ok,
  input wire logic [31:0] ret_addr,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic flag_we,
  input wire logic [3:0] flag_in,
  input wire logic rf_we,
  input wire logic [3:0] rf_waddr,
  input wire logic [31:0] rf_wdata,
  input wire logic [3:0] rf_raddr,
  output logic [31:0] rf_rdata,
  output logic [31:0] current_status_word,
  output logic exec_ok,
  output logic pc_load,
  output logic [31:0] pc_value
);
  import sec_pkg::*;
  function automatic logic [2:0] mode_slot(input logic [4:0] m);
    case (m)
      MODE_FIQ: mode_slot = 3'h0;
      MODE_IRQ: mode_slot = 3'h1;
      MODE_SVC: mode_slot = 3'h2;
      MODE_ABT: mode_slot = 3'h3;
      MODE_UND: mode_slot = 3'h4;
      default: mode_slot = 3'h7;
    endcase
  endfunction
  function automatic logic [4:0] phys_idx(input logic [4:0] m, input logic [3:0] r);
    logic [4:0] base;
    case (m)
      MODE_FIQ: base = RF_BANK_FIQ;
      MODE_IRQ: base = RF_BANK_IRQ;
      MODE_SVC: base = RF_BANK_SVC;
      MODE_ABT: base = RF_BANK_ABT;
      MODE_UND: base = RF_BANK_UND;
      default: base = RF_BANK_USR;
    endcase
    phys_idx = {1'b0, r};
    if (m == MODE_FIQ && r >= 4'h8 && r <= 4'hC) begin
      phys_idx = RF_FIQ_LO + {1'b0, r - 4'h8};
    end else if (r == 4'hD || r == 4'hE) begin
      phys_idx = base + {4'h0, ~r[0]};
    end
  endfunction
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    {n, z, cy, v} = f;
    case (c)
      4'h0: cond_pass = z;
      4'h1: cond_pass = !z;
      4'h2: cond_pass = cy;
      4'h3: cond_pass = !cy;
      4'h4: cond_pass = n;
      4'h5: cond_pass = !n;
      4'h6: cond_pass = v;
      4'h7: cond_pass = !v;
      4'h8: cond_pass = cy && !z;
      4'h9: cond_pass = !cy || z;
      4'hA: cond_pass = n == v;
      4'hB: cond_pass = n != v;
      4'hC: cond_pass = !z && n == v;
      4'hD: cond_pass = z || n != v;
      4'hE: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  endfunction
  logic fiq_s1_q, fiq_s2_q, irq_s1_q, irq_s2_q;
  logic [31:0] current_status_word_q, current_status_word_d;
  logic [31:0] saved_q [0:4];
  logic [31:0] rf_q [0:RF_WORDS-1];
  logic [4:0] pend_q, pend_d, req;
  logic [31:0] pc_value_q, pc_value_d, rf_rdata_q, rf_rdata_d;
  logic pc_load_q, pc_load_d, exec_ok_q, exec_ok_d;
  logic [2:0] grant, cur_slot, tgt_slot;
  logic fire, pass, dp_ret, ldm_ret, ret;
  logic saved_we, lr_we, gp_we;
  logic [2:0] saved_wa;
  logic [31:0] saved_wd;
  logic [4:0] lr_wa, gp_wa, mode;
  logic [4:0] tgt_mode;
  logic [31:0] tgt_vec;
  logic take_ap, wr_q, wr_d, rd_q, rd_d, hreadyout_q, hreadyout_d;
  logic [7:0] off_q, off_d;
  logic [31:0] hrdata_q, hrdata_d;

  assign mode = current_status_word_q[4:0];
  assign cur_slot = mode_slot(mode);

  // Exception requests: slot 0 highest priority
  always_comb begin
    req = {pend_q[EXC_SWI], pend_q[EXC_UND], irq_s2_q && !current_status_word_q[BIT_I],
           fiq_s2_q && !current_status_word_q[BIT_F], pend_q[EXC_ABT]};
    grant = EXC_NONE;
    for (int i = 4; i >= 0; i--) begin
      if (req[i]) begin
        grant = 3'(i);
      end
    end
    fire = take_ok && grant != EXC_NONE;
    case (grant)
      EXC_ABT: begin
        tgt_mode = MODE_ABT;
        tgt_vec = VEC_ABT;
      end
      EXC_FIQ: begin
        tgt_mode = MODE_FIQ;
        tgt_vec = VEC_FIQ;
      end
      EXC_IRQ: begin
        tgt_mode = MODE_IRQ;
        tgt_vec = VEC_IRQ;
      end
      EXC_UND: begin
        tgt_mode = MODE_UND;
        tgt_vec = VEC_UND;
      end
      default: begin
        tgt_mode = MODE_SVC;
        tgt_vec = VEC_SWI;
      end
    endcase
    tgt_slot = mode_slot(tgt_mode);
  end

  // Instruction condition and return decode
  always_comb begin
    pass = current_status_word_q[BIT_T] || cond_pass(instr[31:28], current_status_word_q[31:28]);
    dp_ret = !current_status_word_q[BIT_T] && instr[27:26] == 2'b00 && instr[20] && instr[15:12] == 4'hF
             && !(!instr[25] && instr[7] && instr[4]);
    ldm_ret = !current_status_word_q[BIT_T] && instr[27:25] == 3'b100 && instr[22] && instr[20]
              && instr[15];
    ret = instr_valid && pass && (dp_ret || ldm_ret) && cur_slot != 3'h7 && !fire;
  end

  // Status, saved words, link writes and program counter
  always_comb begin
    current_status_word_d = current_status_word_q;
    pc_value_d = pc_value_q;
    pc_load_d = 1'b0;
    exec_ok_d = instr_valid && pass;
    saved_we = 1'b0;
    saved_wa = cur_slot;
    saved_wd = hwdata;
    lr_we = 1'b0;
    lr_wa = phys_idx(tgt_mode, 4'hE);
    gp_we = rf_we && rf_waddr != 4'hF;
    gp_wa = phys_idx(mode, rf_waddr);
    pend_d = pend_q;
    if (fire) begin
      pend_d[grant] = 1'b0;
    end
    pend_d[EXC_ABT] = pend_d[EXC_ABT] | abort_req;
    pend_d[EXC_UND] = pend_d[EXC_UND] | undef_req;
    pend_d[EXC_SWI] = pend_d[EXC_SWI] | software_trap_req;
    pend_d[EXC_FIQ] = 1'b0;
    pend_d[EXC_IRQ] = 1'b0;
    if (flag_we) begin
      current_status_word_d[BIT_N:BIT_V] = flag_in;
    end
    if (wr_q && off_q == OFF_STATUS) begin
      current_status_word_d = hwdata;
    end
    if (wr_q && off_q == OFF_SAVED && cur_slot != 3'h7) begin
      saved_we = 1'b1;
    end
    if (ret) begin
      current_status_word_d = saved_q[cur_slot];
      pc_value_d = rf_q[phys_idx(mode, 4'hE)];
      pc_load_d = 1'b1;
    end
    if (fire) begin
      saved_we = 1'b1;
      saved_wa = tgt_slot;
      saved_wd = current_status_word_q;
      lr_we = 1'b1;
      current_status_word_d[4:0] = tgt_mode;
      current_status_word_d[BIT_T] = 1'b0;
      current_status_word_d[BIT_I] = 1'b1;
      if (grant == EXC_FIQ) begin
        current_status_word_d[BIT_F] = 1'b1;
      end
      pc_value_d = tgt_vec;
      pc_load_d = 1'b1;
    end
    rf_rdata_d = (rf_raddr == 4'hF) ? pc_value_q : rf_q[phys_idx(mode, rf_raddr)];
  end

  // AHB-Lite slave: writes zero-wait, reads one wait state
  always_comb begin
    take_ap = hsel && htrans[1] && hready;
    wr_d = take_ap && hwrite;
    rd_d = take_ap && !hwrite;
    off_d = take_ap ? haddr[7:0] : off_q;
    hreadyout_d = !rd_d;
    hrdata_d = hrdata_q;
    if (rd_q) begin
      case (off_q)
        OFF_STATUS: hrdata_d = current_status_word_q;
        OFF_SAVED: hrdata_d = (cur_slot != 3'h7) ? saved_q[cur_slot] : 32'h00000000;
        OFF_PEND: hrdata_d = {27'h0, req};
        OFF_LINK: hrdata_d = rf_q[phys_idx(mode, 4'hE)];
        default: hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fiq_s1_q <= 1'b0;
      fiq_s2_q <= 1'b0;
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
      current_status_word_q <= STATUS_RST;
      pend_q <= 5'h00;
      pc_value_q <= 32'h00000000;
      pc_load_q <= 1'b0;
      exec_ok_q <= 1'b0;
      rf_rdata_q <= 32'h00000000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      off_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h00000000;
      for (int i = 0; i < 5; i++) begin
        saved_q[i] <= 32'h00000000;
      end
      for (int i = 0; i < RF_WORDS; i++) begin
        rf_q[i] <= 32'h00000000;
      end
    end else if (clk_en) begin
      fiq_s1_q <= fast_interrupt_pin;
      fiq_s2_q <= fiq_s1_q;
      irq_s1_q <= irq_pin;
      irq_s2_q <= irq_s1_q;
      current_status_word_q <= current_status_word_d;
      pend_q <= pend_d;
      pc_value_q <= pc_value_d;
      pc_load_q <= pc_load_d;
      exec_ok_q <= exec_ok_d;
      rf_rdata_q <= rf_rdata_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      off_q <= off_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q <= hrdata_d;
      if (saved_we) begin
        saved_q[saved_wa] <= saved_wd;
      end
      if (gp_we) begin
        rf_q[gp_wa] <= rf_wdata;
      end
      if (lr_we) begin
        rf_q[lr_wa] <= ret_addr;
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign rf_rdata = rf_rdata_q;
  assign current_status_word = current_status_word_q;
  assign exec_ok = exec_ok_q;
  assign pc_load = pc_load_q;
  assign pc_value = pc_value_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  fiq_entry_a: assert property (clk_en && fire && grant == EXC_FIQ |=>
    mode == MODE_FIQ && current_status_word_q[BIT_F] && pc_load_q && pc_value_q == VEC_FIQ)
    else $error("fast interrupt entry wrong");
  save_prior_a: assert property (clk_en && fire |=>
    saved_q[$past(tgt_slot)] == $past(current_status_word_q)) else $error("prior status not saved");
  link_bank_a: assert property (clk_en && fire |=>
    rf_q[$past(lr_wa)] == $past(ret_addr)) else $error("return address not banked");
  return_copy_a: assert property (clk_en && ret |=>
    current_status_word_q == $past(saved_q[cur_slot]) && pc_load_q) else $error("return copy wrong");
  pend_keep_a: assert property (clk_en && abort_req |=> pend_q[EXC_ABT])
    else $error("abort request lost");
  prio_order_a: assert property (clk_en && take_ok && req[EXC_ABT] && req[EXC_UND] |=>
    mode == MODE_ABT && pend_q[EXC_UND]) else $error("priority order broken");
  fiq_mask_a: assert property (clk_en && current_status_word_q[BIT_F] && !ret && !wr_q &&
    mode != MODE_FIQ |=> mode != MODE_FIQ) else $error("masked fast interrupt taken");
  cond_ne_a: assert property (clk_en && instr_valid && !current_status_word_q[BIT_T] &&
    instr[31:28] == 4'h1 |=> exec_ok_q == !$past(current_status_word_q[BIT_Z])) else $error("condition wrong");
  low_bank_a: assert property (rf_waddr < 4'h8 |-> gp_wa == {1'b0, rf_waddr})
    else $error("low register banked");
  fiq_bank_a: assert property (mode == MODE_FIQ && rf_waddr == 4'h8 |->
    gp_wa == RF_FIQ_LO) else $error("fast bank register wrong");
  flag_upd_a: assert property (clk_en && flag_we && !fire && !ret && !wr_q |=>
    current_status_word_q[BIT_N:BIT_V] == $past(flag_in)) else $error("flags not updated");
endmodule
`default_nettype wire

// file: exc_source.sv
/*
  Far-side model of the interrupt pins and pipeline fault sources.
  Assumes the bench changes cmd by non-blocking assignment at hclk edges.
*/
`default_nettype none
module exc_source (
  input wire logic hclk,
  input wire logic [4:0] cmd,
  output logic abort_req,
  output logic fast_interrupt_pin,
  output logic irq_pin,
  output logic undef_req,
  output logic software_trap_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] prev_q;
  // Pins are asynchronous levels, so they move away from the edge
  assign #3 fast_interrupt_pin = cmd[1];
  assign #3 irq_pin = cmd[2];
  // Faults are one-cycle pulses on each new command
  always_ff @(posedge hclk) begin
    prev_q <= cmd;
    abort_req <= cmd[0] & ~prev_q[0];
    undef_req <= cmd[3] & ~prev_q[3];
    software_trap_req <= cmd[4] & ~prev_q[4];
  end
endmodule
`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench for the status and exception block.
  Assumes sec_pkg and exc_source are compiled first; one clock at 50 MHz.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sec_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, take_ok = 1'b0;
  logic instr_valid = 1'b0, flag_we = 1'b0, rf_we = 1'b0, clk_en = 1'b1;
  logic hready, hreadyout, hresp, exec_ok, pc_load;
  logic abort_req, fast_interrupt_pin, irq_pin, undef_req, software_trap_req;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] flag_in = 4'h0, rf_waddr = 4'h0, rf_raddr = 4'h0;
  logic [4:0] cmd = 5'h00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, ret_addr = 32'h0, instr = 32'h0;
  logic [31:0] rf_wdata = 32'h0, ra = 32'h0;
  logic [31:0] hrdata, rf_rdata, current_status_word, pc_value, rd;
  logic [31:0] vec [5] = '{VEC_ABT, VEC_FIQ, VEC_IRQ, VEC_UND, VEC_SWI};
  logic [4:0] mode [5] = '{MODE_ABT, MODE_FIQ, MODE_IRQ, MODE_UND, MODE_SVC};
  logic [3:0] cc [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hA, 4'hE};
  // Expected pass for each condition with N=1 Z=0 C=1 V=0
  logic [6:0] pass_exp = 7'b1001110;
  int n_mismatch = 0;
  int checks = 0;
  assign hready = hreadyout;
  status_and_exception_control i_dut (
    .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .fast_interrupt_pin, .irq_pin, .abort_req,
    .undef_req, .software_trap_req, .take_ok, .ret_addr, .instr_valid, .instr, .flag_we,
    .flag_in, .rf_we, .rf_waddr, .rf_wdata, .rf_raddr, .rf_rdata, .current_status_word,
    .exec_ok, .pc_load, .pc_value
  );
  exc_source i_src (
    .hclk, .cmd, .abort_req, .fast_interrupt_pin, .irq_pin, .undef_req, .software_trap_req
  );
  initial begin
    forever #10 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic issue(input logic [31:0] x);
    @(posedge hclk);
    instr_valid <= 1'b1;
    instr <= x;
    @(posedge hclk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic wpc(input logic [31:0] v);
    do @(posedge hclk); while (pc_load !== 1'b1);
    chk(pc_value, v);
  endtask
  task automatic wreg(input logic [3:0] n, input logic [31:0] v);
    @(posedge hclk);
    rf_we <= 1'b1;
    rf_waddr <= n;
    rf_wdata <= v;
    @(posedge hclk);
    rf_we <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] n, input logic [31:0] exp);
    @(posedge hclk);
    rf_raddr <= n;
    @(posedge hclk);
    #1 chk(rf_rdata, exp);
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    chk(current_status_word, STATUS_RST);
    chk({29'h0, hreadyout, pc_load, exec_ok}, 32'h4);
    chk(pc_value, 32'h0);
    rdchk(OFF_STATUS, 32'h000000D3);
    rdchk(8'h20, 32'h0);
    bus(1'b1, OFF_PEND, 32'h1F);
    rdchk(OFF_PEND, 32'h0);
    $display("test reset done");
    @(posedge hclk);
    flag_we <= 1'b1;
    flag_in <= 4'hA;
    @(posedge hclk);
    flag_we <= 1'b0;
    #1 chk({28'h0, current_status_word[31:28]}, 32'hA);
    @(posedge hclk);
    clk_en <= 1'b0;
    flag_we <= 1'b1;
    flag_in <= 4'h5;
    @(posedge hclk);
    clk_en <= 1'b1;
    flag_we <= 1'b0;
    @(posedge hclk);
    #1 chk({28'h0, current_status_word[31:28]}, 32'hA);
    for (int k = 0; k < 7; k++) begin
      issue({cc[k], 28'h3A01002});
      chk({31'h0, exec_ok}, {31'h0, pass_exp[k]});
    end
    bus(1'b1, OFF_STATUS, 32'hA00000F3);
    issue(32'h03A01002);
    chk({31'h0, exec_ok}, 32'h1);
    rdchk(OFF_STATUS, 32'hA00000F3);
    $display("test condition done");
    do_reset();
    take_ok <= 1'b1;
    bus(1'b1, OFF_STATUS, 32'h13);
    for (int i = 0; i < 5; i++) begin
      ra = 32'h100 + 32'(i) * 32'h10;
      ret_addr <= ra;
      cmd <= 5'h01 << i;
      wpc(vec[i]);
      cmd <= 5'h00;
      chk({27'h0, current_status_word[4:0]}, {27'h0, mode[i]});
      rdchk(OFF_LINK, ra);
      rdchk(OFF_SAVED, 32'h13);
      issue(i == 4 ? 32'hE8FD8000 : 32'hE1B0F00E);
      wpc(ra);
      rdchk(OFF_STATUS, 32'h13);
    end
    $display("test entry and return done");
    take_ok <= 1'b0;
    cmd <= 5'h1F;
    repeat (4) @(posedge hclk);
    rdchk(OFF_PEND, 32'h1F);
    take_ok <= 1'b1;
    wpc(VEC_ABT);
    wpc(VEC_FIQ);
    wpc(VEC_UND);
    wpc(VEC_SWI);
    cmd <= 5'h00;
    $display("test priority done");
    do_reset();
    bus(1'b1, OFF_STATUS, 32'h13);
    wreg(4'h8, 32'h88);
    wreg(4'hD, 32'hAA);
    wreg(4'h1, 32'h11);
    cmd <= 5'h02;
    wpc(VEC_FIQ);
    cmd <= 5'h00;
    wreg(4'h8, 32'hF8);
    wreg(4'hD, 32'hFD);
    rreg(4'h8, 32'hF8);
    issue(32'hE1B0F00E);
    wpc(ra);
    rreg(4'h8, 32'h88);
    rreg(4'hD, 32'hAA);
    bus(1'b1, OFF_STATUS, 32'h33);
    rreg(4'h1, 32'h11);
    bus(1'b1, OFF_SAVED, 32'h1F);
    rdchk(OFF_SAVED, 32'h1F);
    bus(1'b1, OFF_STATUS, 32'h10);
    rdchk(OFF_SAVED, 32'h0);
    issue(32'hE1B0F00E);
    chk({31'h0, pc_load}, 32'h0);
    $display("test banking done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
